// ==== hw/trb_pkg.sv ====
// Shared constants, state type and checksum function for the reader link
package trb_pkg;

  // Clock and bit timing
  localparam int CLK_PS = 10000;
  localparam int ETU_PS = 9439500;
  // Nominal bit period, rounded to the nearest cycle
  localparam int ETU_CYC = (ETU_PS + CLK_PS / 2) / CLK_PS;
  localparam int ETU_HALF = ETU_CYC / 2;
  localparam int ETU_W = 10;

  // Host handshake gap between two bytes
  localparam int GAP_US = 150;
  localparam int GAP_CYC = GAP_US * 1000000 / CLK_PS;
  localparam int GAP_W = 16;

  // Response timing, counted in bit periods
  localparam int GUARD_MIN_ETU = 8;
  localparam int POLL_TR0_ETU = 32;
  localparam int FWT_BASE_ETU = 32;
  localparam int WAIT_W = 20;
  localparam logic [3:0] FWI_MAX = 4'he;
  localparam logic [3:0] FWI_RESET = 4'h4;
  localparam int ATQB_FWI_IDX = 11;
  localparam logic [3:0] POLL_NIBBLE = 4'h5;

  // Outgoing segments, sent least significant bit first
  localparam logic [11:0] SEG_SOF = 12'hc00;
  localparam logic [3:0] SOF_LEN = 4'hc;
  localparam logic [3:0] BYTE_LEN = 4'ha;
  localparam logic [3:0] EOF_LEN = 4'ha;
  localparam logic [3:0] SOF_LOW_MIN = 4'h9;

  // Buffers and the response header
  localparam int CMD_DEPTH = 64;
  localparam int RESP_DEPTH = 64;
  localparam int RESP_HDR = 2;
  localparam int FLAG_CRC = 0;
  localparam int FLAG_NORESP = 1;
  localparam int FLAG_FRAME = 2;

  // Checksum: generator, preset and good residue
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_POLY_REF = {<<{CRC_POLY}};
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TX = 3'b001,
    ST_WAIT = 3'b010,
    ST_SYNC = 3'b011,
    ST_SOF = 3'b100,
    ST_EDGE = 3'b101,
    ST_BITS = 3'b110,
    ST_DONE = 3'b111
  } trb_state_t;

  // One byte through the reflected checksum, bit 0 first
  function automatic logic [15:0] trbCrcByte(input logic [15:0] crc,
                                             input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ CRC_POLY_REF;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

endpackage

// ==== hw/trb_spi_port.sv ====
// Serial host port logic clocked by the host's serial clock
module trb_spi_port (
  input wire logic spiClk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic sdi,
  input wire logic [7:0] txHold,
  output logic sdoOut,
  output logic sdoEn,
  output logic [7:0] rxByte,
  output logic doneTog
);
  import trb_pkg::*;

  logic [2:0] bitCnt;
  logic [6:0] rxShift;
  logic [7:0] txShift;

  // Bit position; deselect clears it so a torn byte never lingers
  always_ff @(posedge spiClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      bitCnt <= 3'h0;
    end else begin
      bitCnt <= bitCnt + 3'h1;
    end
  end

  // Input shifter, most significant bit first
  always_ff @(posedge spiClk) begin
    if (!chipSelectN) begin
      rxShift <= {rxShift[5:0], sdi};
    end
  end

  // Whole byte held until the next one ends, so the core reads it calmly
  always_ff @(posedge spiClk) begin
    if (!chipSelectN && bitCnt == 3'h7) begin
      rxByte <= {rxShift, sdi};
    end
  end

  // Byte-done event crosses to the core as a toggle
  always_ff @(posedge spiClk or posedge rst) begin
    if (rst) begin
      doneTog <= 1'b0;
    end else if (!chipSelectN && bitCnt == 3'h7) begin
      doneTog <= ~doneTog;
    end
  end

  // Output shifter moves on the falling edge
  always_ff @(negedge spiClk) begin
    if (bitCnt == 3'h1) begin
      txShift <= {txHold[6:0], 1'b0};
    end else begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  // First bit must stand before any clock edge, hence the bypass
  assign sdoOut = (bitCnt == 3'h0) ? txHold[7] : txShift[7];
  assign sdoEn = ~chipSelectN;

endmodule

// ==== hw/trb_reader_link.sv ====
// Type B reader frame engine with serial host port and handshake line
module trb_reader_link #(
  parameter int GAP_CYCLES = trb_pkg::GAP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic sdi,
  output logic sdoOut,
  output logic sdoEn,
  output logic hostStatusHandshake,
  input wire logic interfaceSelectStrap,
  input wire logic subcarrierOn,
  input wire logic subcarrierPhase,
  output logic rfModulate
);
  import trb_pkg::*;

  // Pin synchronisers and strap capture
  logic carMeta, carSync, phMeta, phSync;
  logic strapMeta, strapSync, strapCaught, spiMode;
  logic togMeta, togSync, togLast;

  // Link sequencing
  trb_state_t state;
  logic [ETU_W-1:0] etuCnt;
  logic [WAIT_W-1:0] waitEtu;
  logic [11:0] txBits;
  logic [3:0] bitLeft;
  logic [6:0] byteIdx;
  logic txEof, isPoll, refPhase, locked;
  logic [3:0] lowEtu, rxBitIdx;
  logic [7:0] rxData;
  logic crcErr, noResp, frameErr;
  logic [15:0] crc;
  logic [3:0] fwi, fwiCand;

  // Host command and response storage
  logic [7:0] cmdBuf [CMD_DEPTH];
  logic [7:0] respMem [RESP_DEPTH];
  logic [6:0] cmdLen, cmdCnt, rxCnt, respCnt, respIdx;
  logic lenSeen, pending;
  logic [7:0] txHold, rxHost;
  logic [GAP_W-1:0] gapCnt;
  logic doneTog;

  // Decoded conditions
  logic etuTick, etuMid, bitVal, byteEvt, cmdAccept, startTx;
  logic rxBegin, rxStore, txLoad;
  logic [7:0] txData, flagsNow;
  logic [6:0] dataLen;
  logic [WAIT_W-1:0] waitLimit;

  // Port gated off entirely unless the strap chose it
  logic csnGated;
  assign csnGated = chipSelectN | ~spiMode;

  trb_spi_port u_spi (
    .spiClk(spiClk),
    .rst(rst),
    .chipSelectN(csnGated),
    .sdi(sdi),
    .txHold(txHold),
    .sdoOut(sdoOut),
    .sdoEn(sdoEn),
    .rxByte(rxHost),
    .doneTog(doneTog)
  );

  // Demodulator and byte-done crossings
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carMeta <= 1'b0;
      carSync <= 1'b0;
      phMeta <= 1'b0;
      phSync <= 1'b0;
      togMeta <= 1'b0;
      togSync <= 1'b0;
      togLast <= 1'b0;
    end else begin
      carMeta <= subcarrierOn;
      carSync <= carMeta;
      phMeta <= subcarrierPhase;
      phSync <= phMeta;
      togMeta <= doneTog;
      togSync <= togMeta;
      togLast <= togSync;
    end
  end

  // Strap synchroniser runs through reset so it is settled at release
  always_ff @(posedge core_clk) begin
    strapMeta <= interfaceSelectStrap;
    strapSync <= strapMeta;
  end

  // Strap caught once, on the first edge after release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strapCaught <= 1'b0;
      spiMode <= 1'b0;
    end else if (!strapCaught) begin
      strapCaught <= 1'b1;
      spiMode <= strapSync;
    end
  end

  assign byteEvt = togSync ^ togLast;
  assign etuTick = (etuCnt == ETU_W'(ETU_CYC - 1));
  assign etuMid = (etuCnt == ETU_W'(ETU_HALF));
  assign bitVal = (phSync == refPhase);

  // Polls use the short bound; otherwise 32 periods doubled once per step of the waiting index
  assign waitLimit = isPoll ? WAIT_W'(POLL_TR0_ETU)
                            : WAIT_W'(FWT_BASE_ETU) << fwi;

  assign cmdAccept = byteEvt && !pending && spiMode && state == ST_IDLE;
  assign startTx = state == ST_IDLE && lenSeen && cmdCnt == cmdLen &&
                   !pending;
  assign rxBegin = state == ST_WAIT && carSync &&
                   waitEtu >= WAIT_W'(GUARD_MIN_ETU);
  assign rxStore = state == ST_BITS && carSync && etuMid &&
                   rxBitIdx == 4'h9 && bitVal;
  assign txLoad = state == ST_TX && etuTick && bitLeft == 4'h1 &&
                  !txEof && byteIdx < cmdLen;

  // Outgoing byte: data, then inverted checksum low byte, then high
  assign txData = (byteIdx < cmdLen) ? cmdBuf[byteIdx[5:0]] :
                  (byteIdx == cmdLen) ? ~crc[7:0] : ~crc[15:8];
  assign dataLen = (rxCnt > 7'h2) ? rxCnt - 7'h2 : 7'h0;

  always_comb begin
    flagsNow = 8'h00;
    flagsNow[FLAG_CRC] = crcErr;
    flagsNow[FLAG_NORESP] = noResp;
    flagsNow[FLAG_FRAME] = frameErr;
  end

  // Host bytes: a length first, then that many command bytes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmdLen <= 7'h0;
      cmdCnt <= 7'h0;
      lenSeen <= 1'b0;
    end else if (startTx) begin
      lenSeen <= 1'b0;
    end else if (cmdAccept) begin
      if (!lenSeen) begin
        if (rxHost != 8'h00 && rxHost <= 8'(CMD_DEPTH)) begin
          cmdLen <= rxHost[6:0];
          cmdCnt <= 7'h0;
          lenSeen <= 1'b1;
        end
      end else if (cmdCnt != cmdLen) begin
        cmdBuf[cmdCnt[5:0]] <= rxHost;
        cmdCnt <= cmdCnt + 7'h1;
      end
    end
  end

  // Frame sequencer for both directions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      etuCnt <= '0;
      waitEtu <= '0;
      txBits <= 12'h000;
      bitLeft <= 4'h0;
      byteIdx <= 7'h0;
      txEof <= 1'b0;
      isPoll <= 1'b0;
      refPhase <= 1'b0;
      locked <= 1'b0;
      lowEtu <= 4'h0;
      rxBitIdx <= 4'h0;
      rxData <= 8'h00;
      crcErr <= 1'b0;
      noResp <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      etuCnt <= etuTick ? '0 : etuCnt + 1'b1;
      unique case (state)
        ST_IDLE: begin
          if (startTx) begin
            state <= ST_TX;
            etuCnt <= '0;
            txBits <= SEG_SOF;
            bitLeft <= SOF_LEN;
            byteIdx <= 7'h0;
            txEof <= 1'b0;
            isPoll <= cmdBuf[0][3:0] == POLL_NIBBLE;
            crcErr <= 1'b0;
            noResp <= 1'b0;
            frameErr <= 1'b0;
          end
        end
        ST_TX: begin
          if (etuTick) begin
            if (bitLeft != 4'h1) begin
              txBits <= txBits >> 1;
              bitLeft <= bitLeft - 4'h1;
            end else if (txEof) begin
              state <= ST_WAIT;
              waitEtu <= '0;
            end else if (byteIdx == cmdLen + 7'h2) begin
              txBits <= 12'h000;
              bitLeft <= EOF_LEN;
              txEof <= 1'b1;
            end else begin
              // Start zero, data LSB first, stop one
              txBits <= {2'b00, 1'b1, txData, 1'b0};
              bitLeft <= BYTE_LEN;
              byteIdx <= byteIdx + 7'h1;
            end
          end
        end
        ST_WAIT: begin
          if (etuTick) begin
            waitEtu <= waitEtu + 1'b1;
          end
          // Early subcarrier is not taken before the guard time
          if (rxBegin) begin
            state <= ST_SYNC;
            etuCnt <= '0;
            locked <= 1'b0;
          end else if (waitEtu >= waitLimit) begin
            state <= ST_DONE;
            noResp <= 1'b1;
          end
        end
        ST_SYNC: begin
          if (!carSync) begin
            state <= ST_DONE;
            frameErr <= 1'b1;
          end else if (!locked) begin
            // Sample mid-period, clear of the switch-on transient
            if (etuMid) begin
              refPhase <= phSync;
              locked <= 1'b1;
            end
          end else if (!bitVal) begin
            state <= ST_SOF;
            etuCnt <= '0;
            lowEtu <= 4'h0;
          end
        end
        ST_SOF: begin
          if (!carSync) begin
            state <= ST_DONE;
            frameErr <= 1'b1;
          end else if (bitVal) begin
            if (lowEtu >= SOF_LOW_MIN) begin
              state <= ST_EDGE;
            end else begin
              state <= ST_DONE;
              frameErr <= 1'b1;
            end
          end else if (etuTick && lowEtu != 4'hf) begin
            lowEtu <= lowEtu + 4'h1;
          end
        end
        ST_EDGE: begin
          // Subcarrier loss before the end delimiter spoils the frame
          if (!carSync) begin
            state <= ST_DONE;
            frameErr <= 1'b1;
          end else if (!bitVal) begin
            state <= ST_BITS;
            etuCnt <= '0;
            rxBitIdx <= 4'h0;
          end
        end
        ST_BITS: begin
          if (!carSync) begin
            state <= ST_DONE;
            frameErr <= 1'b1;
          end else if (etuMid) begin
            rxBitIdx <= rxBitIdx + 4'h1;
            if (rxBitIdx == 4'h0) begin
              // A start bit gone high was a glitch
              if (bitVal) begin
                state <= ST_EDGE;
              end
            end else if (rxBitIdx != 4'h9) begin
              rxData <= {bitVal, rxData[7:1]};
            end else if (bitVal) begin
              state <= ST_EDGE;
            end else begin
              // Zero byte with zero stop is the end delimiter
              state <= ST_DONE;
              if (rxData != 8'h00 || rxCnt < 7'h2) begin
                frameErr <= 1'b1;
              end else if (crc != CRC_RESIDUE) begin
                crcErr <= 1'b1;
              end
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Shared checksum, preset at each frame start; framing bits skipped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc <= CRC_PRESET;
    end else if (startTx || rxBegin) begin
      crc <= CRC_PRESET;
    end else if (txLoad) begin
      crc <= trbCrcByte(crc, txData);
    end else if (rxStore) begin
      crc <= trbCrcByte(crc, rxData);
    end
  end

  // Field modulated only while a frame goes out
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rfModulate <= 1'b0;
    end else begin
      rfModulate <= state == ST_TX && !txBits[0];
    end
  end

  // Reply bytes land after the header; overlong frames are cut short
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxCnt <= 7'h0;
      respCnt <= 7'h0;
    end else if (rxBegin) begin
      rxCnt <= 7'h0;
    end else if (rxStore) begin
      if (rxCnt < 7'(RESP_DEPTH - RESP_HDR)) begin
        respMem[6'(rxCnt + 7'(RESP_HDR))] <= rxData;
        rxCnt <= rxCnt + 7'h1;
      end
    end else if (state == ST_DONE) begin
      respMem[0] <= flagsNow;
      respMem[1] <= {1'b0, dataLen};
      respCnt <= dataLen + 7'(RESP_HDR);
    end
  end

  // Waiting-time index kept from the last poll answer when a poll ends without checksum or framing error and rxCnt is past ATQB_FWI_IDX
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fwi <= FWI_RESET;
      fwiCand <= FWI_RESET;
    end else if (rxStore && isPoll && rxCnt == 7'(ATQB_FWI_IDX)) begin
      fwiCand <= (rxData[7:4] > FWI_MAX) ? FWI_MAX : rxData[7:4];
    end else if (state == ST_DONE && isPoll && !crcErr && !frameErr &&
                 rxCnt > 7'(ATQB_FWI_IDX)) begin
      fwi <= fwiCand;
    end
  end

  // Handshake to the host, one byte at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending <= 1'b0;
      hostStatusHandshake <= 1'b0;
      respIdx <= 7'h0;
      gapCnt <= '0;
      txHold <= 8'h00;
    end else if (state == ST_DONE) begin
      pending <= 1'b1;
      hostStatusHandshake <= 1'b1;
      respIdx <= 7'h0;
      txHold <= flagsNow;
    end else if (byteEvt && pending) begin
      hostStatusHandshake <= 1'b0;
      if (respIdx + 7'h1 < respCnt) begin
        respIdx <= respIdx + 7'h1;
        txHold <= respMem[6'(respIdx + 7'h1)];
        gapCnt <= GAP_W'(GAP_CYCLES);
      end else begin
        pending <= 1'b0;
      end
    end else if (gapCnt != '0) begin
      gapCnt <= gapCnt - 1'b1;
      if (gapCnt == GAP_W'(1)) begin
        hostStatusHandshake <= 1'b1;
      end
    end
  end

endmodule

// ==== tb/trb_tb_pkg.sv ====
// Bench-side reference checksum for frame checks
package trb_tb_pkg;
  // Reflected generator, bit 0 first, as sent on the link
  function automatic logic [15:0] refCrc(input logic [15:0] c,
                                         input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction
endpackage

// ==== tb/trb_reader_link_assertions.sv ====
// Concurrent checks on the reader link top-level ports
module trb_reader_link_assertions
  import trb_pkg::*;
#(
  parameter int GAP_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chipSelectN,
  input wire logic sdoEn,
  input wire logic hostStatusHandshake,
  input wire logic interfaceSelectStrap,
  input wire logic rfModulate
);
  logic [19:0] runCnt;
  logic [19:0] lowCnt;
  logic lastMod;
  logic sofSeen;
  logic awaiting;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Length of the current field level, saturating
  always_ff @(posedge core_clk) begin
    lastMod <= rfModulate;
    if (rst) begin
      runCnt <= 20'(ETU_CYC);
    end else if (rfModulate != lastMod) begin
      runCnt <= 20'h1;
    end else if (runCnt != 20'hfffff) begin
      runCnt <= runCnt + 20'h1;
    end
  end
  // Long modulated runs alternate between frame start and frame end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sofSeen <= 1'b0;
      awaiting <= 1'b0;
    end else begin
      // Nine periods can be a zero byte; only delimiters reach ten
      if (lastMod && !rfModulate && runCnt >= 20'(10 * ETU_CYC)) begin
        sofSeen <= !sofSeen;
        awaiting <= sofSeen;
      end
      if (hostStatusHandshake) begin
        awaiting <= 1'b0;
      end
    end
  end
  // Time spent low by the handshake; a gap that is too short is a hazard
  always_ff @(posedge core_clk) begin
    if (rst || hostStatusHandshake) begin
      lowCnt <= 20'h0;
    end else if (lowCnt != 20'hfffff) begin
      lowCnt <= lowCnt + 20'h1;
    end
  end
  sequence hsLow;
    !hostStatusHandshake [*8];
  endsequence
  cs_float_a: assert property (chipSelectN |-> !sdoEn)
    else $error("serial output driven while deselected");
  strap_gate_a: assert property (sdoEn |-> $past(interfaceSelectStrap, 3))
    else $error("serial output driven with strap low");
  bit_min_a: assert property ($changed(rfModulate) |-> runCnt >= 20'(ETU_CYC))
    else $error("field level shorter than one bit period");
  mod_max_a: assert property (rfModulate && !$changed(rfModulate) |-> runCnt < 20'(10 * ETU_CYC))
    else $error("modulated run longer than ten bit periods");
  quiet_wait_a: assert property (awaiting |-> !rfModulate)
    else $error("field modulated while awaiting a reply");
  pend_hold_a: assert property (hostStatusHandshake |-> !rfModulate)
    else $error("transmission while response data pending");
  gap_hold_a: assert property ($fell(hostStatusHandshake) |-> hsLow)
    else $error("handshake gap too short");
  gap_len_a: assert property ($rose(hostStatusHandshake) |-> lowCnt >= 20'(GAP_CYCLES - 1))
    else $error("handshake rose before the gap ended");
endmodule

bind trb_reader_link trb_reader_link_assertions #(
  .GAP_CYCLES(GAP_CYCLES)
) trb_reader_link_assertions_i (
  .core_clk(core_clk),
  .rst(rst),
  .chipSelectN(chipSelectN),
  .sdoEn(sdoEn),
  .hostStatusHandshake(hostStatusHandshake),
  .interfaceSelectStrap(interfaceSelectStrap),
  .rfModulate(rfModulate)
);

// ==== tb/trb_card_model.sv ====
// Behavioural card answering one command frame over the subcarrier
module trb_card_model
  import trb_pkg::*;
  import trb_tb_pkg::*;
#(
  parameter logic [7:0] REPLY = 8'h42,
  parameter bit BAD_CRC = 1'b1
) (
  input wire logic core_clk,
  input wire logic rfModulate,
  output logic subcarrierOn,
  output logic subcarrierPhase
);
  logic ph;
  logic tgl = 1'b0;
  // Phase line is noise while the subcarrier is off
  assign subcarrierPhase = subcarrierOn ? ph : tgl;
  always @(posedge core_clk) begin
    tgl <= ~tgl;
  end
  // One level for n bit periods; a one keeps the reference phase
  task automatic sym(input logic one, input int n);
    ph <= !one;
    repeat (n * ETU_CYC) @(posedge core_clk);
  endtask
  task automatic sendByte(input logic [7:0] b);
    sym(1'b0, 1);
    for (int i = 0; i < 8; i++) sym(b[i], 1);
    sym(1'b1, 1);
  endtask
  // Reply after the command's end of frame
  initial begin
    int n;
    int k;
    logic [15:0] c;
    subcarrierOn = 1'b0;
    ph = 1'b0;
    k = 0;
    while (k < 2) begin
      @(posedge core_clk);
      n = 0;
      while (rfModulate === 1'b1) begin
        @(posedge core_clk);
        n++;
      end
      if (n > 9 * ETU_CYC) k++;
    end
    repeat (10 * ETU_CYC) @(posedge core_clk);
    c = ~refCrc(16'hffff, REPLY);
    c[0] = c[0] ^ BAD_CRC;
    subcarrierOn <= 1'b1;
    sym(1'b1, 4);
    sym(1'b0, 10);
    sym(1'b1, 2);
    sendByte(REPLY);
    sendByte(c[7:0]);
    sendByte(c[15:8]);
    sym(1'b0, 10);
    sym(1'b1, 1);
    subcarrierOn <= 1'b0;
  end
endmodule

// ==== tb/trb_reader_link_bench.sv ====
// Self-checking bench: host serial port, command frame, card reply
module trb_reader_link_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import trb_pkg::*;
  import trb_tb_pkg::*;
  localparam int GAP = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic spiClk = 1'b0;
  logic chipSelectN = 1'b1;
  logic sdi = 1'b0;
  logic interfaceSelectStrap = 1'b0;
  logic sdoOut;
  logic sdoEn;
  logic hostStatusHandshake;
  logic subcarrierOn;
  logic subcarrierPhase;
  logic rfModulate;
  int fails = 0;
  int samplesChecked = 0;
  trb_reader_link #(.GAP_CYCLES(GAP)) trb_reader_link_i (
    .core_clk(core_clk),
    .rst(rst),
    .spiClk(spiClk),
    .chipSelectN(chipSelectN),
    .sdi(sdi),
    .sdoOut(sdoOut),
    .sdoEn(sdoEn),
    .hostStatusHandshake(hostStatusHandshake),
    .interfaceSelectStrap(interfaceSelectStrap),
    .subcarrierOn(subcarrierOn),
    .subcarrierPhase(subcarrierPhase),
    .rfModulate(rfModulate)
  );
  trb_card_model trb_card_model_i (
    .core_clk(core_clk),
    .rfModulate(rfModulate),
    .subcarrierOn(subcarrierOn),
    .subcarrierPhase(subcarrierPhase)
  );
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One byte MSB first; data moves only while the serial clock is low
  task automatic spiByte(input logic [7:0] tx, input logic csN,
                         output logic [7:0] rx);
    chipSelectN <= csN;
    #7;
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      #6 rx[i] = sdoOut;
      spiClk <= 1'b1;
      #6 spiClk <= 1'b0;
    end
    #6 chipSelectN <= 1'b1;
    #60;
  endtask
  // Wait for a ready byte, read it, then time the low gap that follows
  task automatic readByte(input int lim, output logic [7:0] rx,
                          output int gap);
    int n;
    n = 0;
    while (hostStatusHandshake !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    check(hostStatusHandshake === 1'b1, "no byte ready");
    gap = 0;
    // The fall comes after the last clock edge, while the transfer task still runs, so the gap is timed alongside it
    fork
      spiByte(8'h00, 1'b0, rx);
      begin
        n = 0;
        while (hostStatusHandshake === 1'b1 && n < 30) begin
          @(posedge core_clk);
          n++;
        end
        check(hostStatusHandshake === 1'b0, "handshake stuck high");
        while (hostStatusHandshake !== 1'b1 && gap < 4 * GAP) begin
          @(posedge core_clk);
          gap++;
        end
      end
    join
  endtask
  initial begin
    logic [7:0] rx;
    logic [51:0] e;
    logic [15:0] c;
    int n;
    // Strap low: the serial port stays dead
    cyc(6);
    rst <= 1'b0;
    cyc(3);
    chipSelectN <= 1'b0;
    cyc(2);
    check(sdoEn === 1'b0, "port alive, strap low");
    spiByte(8'h01, 1'b0, rx);
    spiByte(8'h05, 1'b0, rx);
    cyc(20);
    check(rfModulate === 1'b0, "command taken, strap low");
    // Restart with the port selected; clocks while deselected are noise
    rst <= 1'b1;
    interfaceSelectStrap <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    cyc(3);
    check(sdoEn === 1'b0, "driven while deselected");
    spiByte(8'h01, 1'b1, rx);
    chipSelectN <= 1'b0;
    cyc(2);
    check(sdoEn === 1'b1, "not driven when selected");
    spiByte(8'h01, 1'b0, rx);
    spiByte(8'h05, 1'b0, rx);
    // Poll frame on the field, checksum inverted and appended
    c = ~refCrc(16'hffff, 8'h05);
    e = {10'h3ff, 1'b0, ~c[15:8], 1'b1, 1'b0, ~c[7:0], 1'b1,
         1'b0, ~8'h05, 1'b1, 2'b00, 10'h3ff};
    n = 0;
    while (rfModulate !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    cyc(ETU_HALF);
    for (int i = 0; i < 52; i++) begin
      check(rfModulate === e[i], "field bit");
      cyc(ETU_CYC);
    end
    // Reply with a broken checksum: flags, length, data
    readByte(100000, rx, n);
    check(rx === 8'h01, "flags");
    check(n >= GAP - 2 && n <= GAP + 2, "gap length");
    readByte(100, rx, n);
    check(rx === 8'h01, "length");
    check(n >= GAP - 2 && n <= GAP + 2, "gap length");
    readByte(100, rx, n);
    check(rx === 8'h42, "data");
    check(n === 4 * GAP, "handshake after last byte");
    conclude();
  end
  // Whole run is about 1.1 ms; cut a hang well after that
  initial begin
    #3000000;
    fails++;
    $display("[ERR] %0t timeout", $time);
    conclude();
  end
endmodule
